// ==== logic/ll_regs_params.svh ====
`ifndef LL_REGS_PARAMS_SVH
`define LL_REGS_PARAMS_SVH

// Register byte addresses.
`define ZONE_UPPER_OFS    32'h40000058
`define ZONE_LOWER_OFS    32'h4000005C
`define FAULT_STATUS_OFS  32'h40000060
`define PROFILE_OFS       32'h40000064
`define CORR_CTRL_OFS     32'h40000070
`define RSEL_CTRL_OFS     32'h40000074
`define POWER_PHASE_OFS   32'h40000080

// Fault status bit positions.
`define BAD_FORMAT_BIT    11
`define NULL_TXPTR_BIT    10
`define RADIO_MEM_BIT     8
`define CHMAP_COUNT_BIT   7
`define FRAME_GAP_BIT     6
`define RX_DECIPHER_BIT   5
`define ALLOW_LIST_BIT    4
`define PREFETCH_BIT      3
`define TX_DESC_BIT       2
`define PKT_MEM_BIT       1
`define TX_ENCIPHER_BIT   0
`define FAULT_MASK        12'hDFF

// Field positions.
`define DC_COMP_BIT       22
`define RSEL_LSB          16
`define RTRIP_LSB         24
`define RX_WARMUP_LSB     16
`define TX_COOLDOWN_LSB   8
`define TX_WARMUP_LSB     0

// Reset values.
`define CORR_FIXED_RST    22'h002102
`define RX_WARMUP_RST     8'hD2
`define TX_COOLDOWN_RST   4'h3
`define TX_WARMUP_RST     8'hD2

`endif

// ==== logic/ll_regs_pkg.sv ====
package ll_regs_pkg;

  // Whole state of the register slice.
  typedef struct packed {
    logic [15:0] zone_upper_bound;
    logic [15:0] zone_lower_bound;
    logic [11:0] link_fault_status;
    logic [31:0] profile_value;
    logic        dc_comp_path_enable;
    logic [4:0]  radio_select_field;
    logic [6:0]  round_trip_delay;
    logic [7:0]  rx_warmup_length;
    logic [3:0]  tx_cooldown_extension;
    logic [7:0]  tx_warmup_length;
    logic [31:0] rd_data;
    logic [31:0] diag_out;
  } regs_s;

endpackage

// ==== logic/ll_core_error_radio_timing_regs.sv ====
// Summary of operation
// [RULE1] Debug zone upper bound: 16-bit read/write, resets to zero.
// [RULE2] Debug zone lower bound: 16-bit read/write, resets to zero.
// [RULE3] Bit 11 flags an invalid control-structure format value.
// [RULE4] Bit 10 flags a null transmit pointer in the control structure.
// [RULE5] Bit 8 flags a late radio controller exchange-memory access.
// [RULE6] Bit 7 flags channel map ones differing from good count at hop start.
// [RULE7] Bit 6 flags an inter-frame space too short for its tasks.
// [RULE8] Bit 5 flags receive decryption unfinished before frame space ends.
// [RULE9] Bit 4 flags allow-list parsing not finished in time.
// [RULE10] Bit 3 flags three consecutive exchange-table entries for prefetch.
// [RULE11] Bit 2 flags a fetched transmit descriptor without completion bit.
// [RULE12] Bit 1 flags a late packet controller exchange-memory access.
// [RULE13] Bit 0 flags transmit encryption unfinished when payload is due.
// [RULE14] A 32-bit profiling word is read/write and copied to diagnostic port.
// [RULE15] Software keeps the DC-compensated correlator path enable at zero.
// [RULE16] Software writes 00011 to the radio select field; it resets to zero.
// [RULE17] Round-trip delay in microseconds lives at bits 30:24.
// [RULE18] Receive warm-up length at bits 23:16, resets to 210 microseconds.
// [RULE19] Transmit cool-down extension at bits 11:8, resets to 3 microseconds.
// [RULE20] Transmit warm-up length at bits 7:0, resets to 210 microseconds.
// [RULE21] With the diagnostic port disabled its outputs are all zero; here they clear one cycle after the enable drops.
// [RULE22] Fault flags stay set until reset; writes ignored; reserved bits zero.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ll_regs_params.svh"

module ll_core_error_radio_timing_regs
  import ll_regs_pkg::*;
#(
  parameter int CHMAP_W = 37,
  parameter int CHCNT_W = 6
)(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [31:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  input  wire logic               format_invalid_event,
  input  wire logic               tx_ptr_check,
  input  wire logic [15:0]        structure_tx_pointer,
  input  wire logic               radio_memory_late_event,
  input  wire logic               hop_start,
  input  wire logic [CHMAP_W-1:0] structure_channel_map,
  input  wire logic [CHCNT_W-1:0] structure_good_channel_count,
  input  wire logic               frame_gap_underrun_event,
  input  wire logic               rx_decipher_late_event,
  input  wire logic               allow_list_timeout_event,
  input  wire logic               prefetch_overrun_event,
  input  wire logic               descriptor_fetched,
  input  wire logic               tx_complete_bit,
  input  wire logic               packet_memory_late_event,
  input  wire logic               tx_encipher_late_event,
  input  wire logic               diag_port_enable,
  output logic      [31:0]        diag_out,
  output logic      [11:0]        link_fault_status,
  output logic      [15:0]        zone_upper_bound,
  output logic      [15:0]        zone_lower_bound,
  output logic                    dc_comp_path_enable,
  output logic      [4:0]         radio_select_field,
  output logic      [6:0]         round_trip_delay,
  output logic      [7:0]         rx_warmup_length,
  output logic      [3:0]         tx_cooldown_extension,
  output logic      [7:0]         tx_warmup_length
);

  regs_s              state;
  regs_s              next_state;
  logic [CHCNT_W-1:0] map_ones;
  logic [11:0]        fault_hits;

  // Count the channels marked usable; a plain adder chain is fine at this width.
  always_comb
  begin
    map_ones = '0;
    for (int i = 0; i < CHMAP_W; i++)
    begin
      map_ones = map_ones + CHCNT_W'(structure_channel_map[i]);
    end
  end

  // Collect this cycle's fault events into one vector.
  always_comb
  begin
    fault_hits = '0;
    fault_hits[`BAD_FORMAT_BIT]  = format_invalid_event;                        // RULE3
    fault_hits[`NULL_TXPTR_BIT]  = tx_ptr_check && (structure_tx_pointer == '0); // RULE4
    fault_hits[`RADIO_MEM_BIT]   = radio_memory_late_event;                     // RULE5
    fault_hits[`CHMAP_COUNT_BIT] = hop_start && (map_ones != structure_good_channel_count); // RULE6
    fault_hits[`FRAME_GAP_BIT]   = frame_gap_underrun_event;                    // RULE7
    fault_hits[`RX_DECIPHER_BIT] = rx_decipher_late_event;                      // RULE8
    fault_hits[`ALLOW_LIST_BIT]  = allow_list_timeout_event;                    // RULE9
    fault_hits[`PREFETCH_BIT]    = prefetch_overrun_event;                      // RULE10
    fault_hits[`TX_DESC_BIT]     = descriptor_fetched && !tx_complete_bit;      // RULE11
    fault_hits[`PKT_MEM_BIT]     = packet_memory_late_event;                    // RULE12
    fault_hits[`TX_ENCIPHER_BIT] = tx_encipher_late_event;                      // RULE13
  end

  // Next-state logic: register writes, fault capture, read mux and diagnostic copy.
  always_comb
  begin
    next_state = state;
    // Flags only ever accumulate, so no software clear can race an event.
    next_state.link_fault_status = (state.link_fault_status | fault_hits) & `FAULT_MASK; // RULE22
    if (reg_wr)
    begin
      case (reg_addr)
        `ZONE_UPPER_OFS:
        begin
          next_state.zone_upper_bound = reg_wdata[15:0]; // RULE1
        end
        `ZONE_LOWER_OFS:
        begin
          next_state.zone_lower_bound = reg_wdata[15:0]; // RULE2
        end
        `PROFILE_OFS:
        begin
          next_state.profile_value = reg_wdata; // RULE14
        end
        `CORR_CTRL_OFS:
        begin
          next_state.dc_comp_path_enable = reg_wdata[`DC_COMP_BIT];
        end
        `RSEL_CTRL_OFS:
        begin
          next_state.radio_select_field = reg_wdata[`RSEL_LSB +: 5];
        end
        `POWER_PHASE_OFS:
        begin
          next_state.round_trip_delay      = reg_wdata[`RTRIP_LSB +: 7];       // RULE17
          next_state.rx_warmup_length      = reg_wdata[`RX_WARMUP_LSB +: 8];   // RULE18
          next_state.tx_cooldown_extension = reg_wdata[`TX_COOLDOWN_LSB +: 4]; // RULE19
          next_state.tx_warmup_length      = reg_wdata[`TX_WARMUP_LSB +: 8];   // RULE20
        end
        default:
        begin
          // The fault word and unmapped addresses ignore writes.
          next_state.profile_value = state.profile_value; // RULE22
        end
      endcase
    end
    // Read data stands only in the cycle after the strobe; otherwise zero.
    next_state.rd_data = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `ZONE_UPPER_OFS:
        begin
          next_state.rd_data[15:0] = state.zone_upper_bound;
        end
        `ZONE_LOWER_OFS:
        begin
          next_state.rd_data[15:0] = state.zone_lower_bound;
        end
        `FAULT_STATUS_OFS:
        begin
          next_state.rd_data[11:0] = state.link_fault_status; // RULE22
        end
        `PROFILE_OFS:
        begin
          next_state.rd_data = state.profile_value;
        end
        `CORR_CTRL_OFS:
        begin
          next_state.rd_data[21:0]        = `CORR_FIXED_RST;
          next_state.rd_data[`DC_COMP_BIT] = state.dc_comp_path_enable;
        end
        `RSEL_CTRL_OFS:
        begin
          next_state.rd_data[`RSEL_LSB +: 5] = state.radio_select_field;
        end
        `POWER_PHASE_OFS:
        begin
          next_state.rd_data[`RTRIP_LSB +: 7]       = state.round_trip_delay;
          next_state.rd_data[`RX_WARMUP_LSB +: 8]   = state.rx_warmup_length;
          next_state.rd_data[`TX_COOLDOWN_LSB +: 4] = state.tx_cooldown_extension;
          next_state.rd_data[`TX_WARMUP_LSB +: 8]   = state.tx_warmup_length;
        end
        default:
        begin
          next_state.rd_data = '0;
        end
      endcase
    end
    // The diagnostic copy trails the profiling word by one cycle.
    next_state.diag_out = diag_port_enable ? state.profile_value : '0; // RULE21
  end

  // State register with constant reset values.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                       <= '0;
      state.rx_warmup_length      <= `RX_WARMUP_RST;   // RULE18
      state.tx_cooldown_extension <= `TX_COOLDOWN_RST; // RULE19
      state.tx_warmup_length      <= `TX_WARMUP_RST;   // RULE20
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata             = state.rd_data;
  assign diag_out              = state.diag_out;
  assign link_fault_status     = state.link_fault_status;
  assign zone_upper_bound      = state.zone_upper_bound;
  assign zone_lower_bound      = state.zone_lower_bound;
  assign dc_comp_path_enable   = state.dc_comp_path_enable;
  assign radio_select_field    = state.radio_select_field;
  assign round_trip_delay      = state.round_trip_delay;
  assign rx_warmup_length      = state.rx_warmup_length;
  assign tx_cooldown_extension = state.tx_cooldown_extension;
  assign tx_warmup_length      = state.tx_warmup_length;

  // Checks on the register slice.
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // A write to the upper bound shows on a read in the following cycle.
  upper_bound_write_a: assert property ( // RULE1
    (reg_wr && reg_addr == `ZONE_UPPER_OFS) ##1 (reg_rd && reg_addr == `ZONE_UPPER_OFS)
    |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 2)})
    else $error("Upper bound read back differs from write.");

  // The lower bound output follows a write one cycle later.
  lower_bound_write_a: assert property ( // RULE2
    reg_wr && reg_addr == `ZONE_LOWER_OFS |=> zone_lower_bound == $past(reg_wdata[15:0]))
    else $error("Lower bound did not take the written value.");

  // An invalid format event raises bit 11 on the next edge.
  format_fault_a: assert property ( // RULE3
    format_invalid_event |=> link_fault_status[`BAD_FORMAT_BIT])
    else $error("Format fault not raised.");

  // A null pointer check raises bit 10 on the next edge.
  null_pointer_a: assert property ( // RULE4
    tx_ptr_check && structure_tx_pointer == 16'h0000 |=> link_fault_status[`NULL_TXPTR_BIT])
    else $error("Null pointer fault not raised.");

  // A mismatched channel count at hop start raises bit 7.
  chmap_count_a: assert property ( // RULE6
    hop_start && map_ones != structure_good_channel_count
    |=> link_fault_status[`CHMAP_COUNT_BIT])
    else $error("Channel map count fault not raised.");

  // A fetched descriptor lacking completion raises bit 2.
  tx_desc_fault_a: assert property ( // RULE11
    descriptor_fetched && !tx_complete_bit |=> link_fault_status[`TX_DESC_BIT])
    else $error("Descriptor fault not raised.");

  // Raised flags never fall while reset is released, and bit 9 stays clear.
  fault_sticky_a: assert property ( // RULE22
    ((link_fault_status & $past(link_fault_status)) == $past(link_fault_status))
    && !link_fault_status[9])
    else $error("Fault flag cleared or reserved bit set.");

  // The status word read shows the flags with upper bits zero.
  fault_read_a: assert property ( // RULE22
    reg_rd && reg_addr == `FAULT_STATUS_OFS
    |=> reg_rdata[31:12] == 20'h00000 && reg_rdata[11:0] == $past(link_fault_status))
    else $error("Fault status read wrong.");

  // Enabled diagnostic port carries the profiling word of the prior cycle.
  diag_copy_a: assert property ( // RULE14
    diag_port_enable |=> diag_out == $past(state.profile_value))
    else $error("Diagnostic port does not mirror profiling word.");

  // A disabled diagnostic port drives zero.
  diag_gate_a: assert property ( // RULE21
    !diag_port_enable |=> diag_out == 32'h00000000)
    else $error("Disabled diagnostic port not zero.");

  // A power phase write updates all four timing fields together.
  power_phase_write_a: assert property ( // RULE20
    reg_wr && reg_addr == `POWER_PHASE_OFS
    |=> tx_warmup_length == $past(reg_wdata[7:0]) && rx_warmup_length == $past(reg_wdata[23:16])
        && tx_cooldown_extension == $past(reg_wdata[11:8]) && round_trip_delay == $past(reg_wdata[30:24]))
    else $error("Power phase fields not updated.");

  // Read data is zero in any cycle not following a read strobe.
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("Read data outside its cycle.");

  // The upper bound output follows a write one cycle later.
  upper_bound_out_a: assert property ( // RULE1
    reg_wr && reg_addr == `ZONE_UPPER_OFS |=> zone_upper_bound == $past(reg_wdata[15:0]))
    else $error("Upper bound did not take the written value.");

  // A late radio controller memory access raises bit 8.
  radio_mem_fault_a: assert property ( // RULE5
    radio_memory_late_event |=> link_fault_status[`RADIO_MEM_BIT])
    else $error("Radio memory fault not raised.");

  // A frame gap underrun raises bit 6.
  frame_gap_fault_a: assert property ( // RULE7
    frame_gap_underrun_event |=> link_fault_status[`FRAME_GAP_BIT])
    else $error("Frame gap fault not raised.");

  // Receive decryption that runs late raises bit 5.
  rx_decipher_fault_a: assert property ( // RULE8
    rx_decipher_late_event |=> link_fault_status[`RX_DECIPHER_BIT])
    else $error("Receive decryption fault not raised.");

  // An allow-list parsing timeout raises bit 4.
  allow_list_fault_a: assert property ( // RULE9
    allow_list_timeout_event |=> link_fault_status[`ALLOW_LIST_BIT])
    else $error("Allow-list fault not raised.");

  // A prefetch overrun raises bit 3.
  prefetch_fault_a: assert property ( // RULE10
    prefetch_overrun_event |=> link_fault_status[`PREFETCH_BIT])
    else $error("Prefetch fault not raised.");

  // A late packet controller memory access raises bit 1.
  pkt_mem_fault_a: assert property ( // RULE12
    packet_memory_late_event |=> link_fault_status[`PKT_MEM_BIT])
    else $error("Packet memory fault not raised.");

  // Transmit encryption that runs late raises bit 0.
  tx_encipher_fault_a: assert property ( // RULE13
    tx_encipher_late_event |=> link_fault_status[`TX_ENCIPHER_BIT])
    else $error("Transmit encryption fault not raised.");

  // A valid pointer must not raise bit 10, or every check would look like a failure.
  null_pointer_clean_a: assert property ( // RULE4
    tx_ptr_check && structure_tx_pointer != 16'h0000 && !link_fault_status[`NULL_TXPTR_BIT]
    |=> !link_fault_status[`NULL_TXPTR_BIT])
    else $error("Null pointer fault raised for a valid pointer.");

  // A matching channel count at hop start leaves bit 7 clear.
  chmap_match_a: assert property ( // RULE6
    hop_start && map_ones == structure_good_channel_count && !link_fault_status[`CHMAP_COUNT_BIT]
    |=> !link_fault_status[`CHMAP_COUNT_BIT])
    else $error("Channel map fault raised for a matching count.");

  // A completed descriptor leaves bit 2 clear.
  tx_desc_clean_a: assert property ( // RULE11
    descriptor_fetched && tx_complete_bit && !link_fault_status[`TX_DESC_BIT]
    |=> !link_fault_status[`TX_DESC_BIT])
    else $error("Descriptor fault raised for a completed descriptor.");

  // Without an event the flags hold, whatever software writes.
  flags_quiet_a: assert property ( // RULE22
    !(|fault_hits) |=> $stable(link_fault_status))
    else $error("Fault flags changed without an event.");

  // A profiling word write lands in the stored word one cycle later.
  profile_write_a: assert property ( // RULE14
    reg_wr && reg_addr == `PROFILE_OFS |=> state.profile_value == $past(reg_wdata))
    else $error("Profiling word did not take the written value.");

  // A correlator control write updates the path enable bit.
  corr_write_a: assert property (
    reg_wr && reg_addr == `CORR_CTRL_OFS |=> dc_comp_path_enable == $past(reg_wdata[`DC_COMP_BIT]))
    else $error("Correlator path enable did not take the written value.");

  // A radio select write updates the five-bit field.
  rsel_write_a: assert property ( // RULE16
    reg_wr && reg_addr == `RSEL_CTRL_OFS |=> radio_select_field == $past(reg_wdata[`RSEL_LSB +: 5]))
    else $error("Radio select field did not take the written value.");

  // Main scenarios.
  fault_seen_c: cover property (hop_start ##1 link_fault_status[`CHMAP_COUNT_BIT]);
  power_rw_c: cover property ((reg_wr && reg_addr == `POWER_PHASE_OFS)
                              ##1 (reg_rd && reg_addr == `POWER_PHASE_OFS));
  diag_on_c: cover property (diag_port_enable ##1 diag_out != 32'h00000000);
  ptr_ok_c: cover property (tx_ptr_check && structure_tx_pointer != 16'h0000);
  status_rd_c: cover property ((reg_rd && reg_addr == `FAULT_STATUS_OFS) ##1 reg_rdata != 32'h00000000);

endmodule

// ==== testbench/fault_source.sv ====
`timescale 1ns/1ps

// Far-side event source: each fire bit becomes a one-cycle pulse on the matching fault line.
module fault_source (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] fire,
  input  wire logic        ok,
  output logic      [11:0] pulse,
  output logic      [15:0] structure_tx_pointer,
  output logic      [36:0] structure_channel_map,
  output logic      [5:0]  structure_good_channel_count,
  output logic             tx_complete_bit
);
  logic ok_q;

  // Pulses are registered so that they leave right after an edge, as a real source would.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse <= 12'h000;
      ok_q  <= 1'b1;
    end
    else
    begin
      pulse <= fire;
      ok_q  <= ok;
    end
  end

  // Qualifiers are only meaningful beside their check pulse; otherwise they show an unrelated value.
  assign structure_tx_pointer = pulse[10] ? (ok_q ? 16'h0100 : 16'h0000) : 16'hFFFF;
  assign structure_channel_map = 37'h000000001F;
  assign structure_good_channel_count = ok_q ? 6'h05 : 6'h06;
  assign tx_complete_bit = ok_q | ~pulse[2];
endmodule

// ==== testbench/ll_core_error_radio_timing_regs_test.sv ====
`timescale 1ns/1ps
`include "ll_regs_params.svh"

module ll_core_error_radio_timing_regs_test;
  import ll_regs_pkg::*;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] rst;
    logic [31:0] wd;
    logic [31:0] rb;
  } row_s;

  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] fire = 12'h000;
  logic        ok = 1'b1;
  logic        diag_port_enable = 1'b0;
  logic [11:0] pulse;
  logic [15:0] ptr;
  logic [36:0] chmap;
  logic [5:0]  chcnt;
  logic        txc;
  logic [31:0] diag_out;
  logic [11:0] link_fault_status;
  logic [15:0] zone_upper_bound;
  logic [15:0] zone_lower_bound;
  logic        dc_comp_path_enable;
  logic [4:0]  radio_select_field;
  logic [6:0]  round_trip_delay;
  logic [7:0]  rx_warmup_length;
  logic [3:0]  tx_cooldown_extension;
  logic [7:0]  tx_warmup_length;
  logic [31:0] d;
  logic [31:0] exp_f;
  int          failures = 0;
  int          total_checks = 0;

  // Address, reset value, write data, expected read-back.
  row_s rows [8] = '{
    '{`ZONE_UPPER_OFS, 32'h0, 32'hFFFFFFFF, 32'h0000FFFF},
    '{`ZONE_LOWER_OFS, 32'h0, 32'hA5A5A5A5, 32'h0000A5A5},
    '{`FAULT_STATUS_OFS, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{`PROFILE_OFS, 32'h0, 32'hDEADBEEF, 32'hDEADBEEF},
    '{`CORR_CTRL_OFS, 32'h00002102, 32'hFFBFFFFF, 32'h00002102},
    '{`RSEL_CTRL_OFS, 32'h0, 32'hFFE3FFFF, 32'h00030000},
    '{`POWER_PHASE_OFS, 32'h00D203D2, 32'hFFFFFFFF, 32'h7FFF0FFF},
    '{32'h40000068, 32'h0, 32'h12345678, 32'h0}
  };

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  fault_source src (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .ok(ok), .pulse(pulse),
    .structure_tx_pointer(ptr), .structure_channel_map(chmap), .structure_good_channel_count(chcnt),
    .tx_complete_bit(txc));

  ll_core_error_radio_timing_regs dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .format_invalid_event(pulse[11]), .tx_ptr_check(pulse[10]), .structure_tx_pointer(ptr),
    .radio_memory_late_event(pulse[8]), .hop_start(pulse[7]), .structure_channel_map(chmap),
    .structure_good_channel_count(chcnt), .frame_gap_underrun_event(pulse[6]),
    .rx_decipher_late_event(pulse[5]), .allow_list_timeout_event(pulse[4]),
    .prefetch_overrun_event(pulse[3]), .descriptor_fetched(pulse[2]), .tx_complete_bit(txc),
    .packet_memory_late_event(pulse[1]), .tx_encipher_late_event(pulse[0]),
    .diag_port_enable(diag_port_enable), .diag_out(diag_out), .link_fault_status(link_fault_status),
    .zone_upper_bound(zone_upper_bound), .zone_lower_bound(zone_lower_bound),
    .dc_comp_path_enable(dc_comp_path_enable), .radio_select_field(radio_select_field),
    .round_trip_delay(round_trip_delay), .rx_warmup_length(rx_warmup_length),
    .tx_cooldown_extension(tx_cooldown_extension), .tx_warmup_length(tx_warmup_length));

  // Compares one 32-bit result and counts it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Write then read back with no gap, so the read sees the write of the cycle before.
  task wr_rd(input logic [31:0] a, input logic [31:0] v, output logic [31:0] rv);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge core_clk);
    reg_rd    <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // Fires one far-side event and lets it land in the status flags.
  task shoot(input int i, input logic good);
    @(posedge core_clk);
    fire <= 12'h001 << i;
    ok   <= good;
    @(posedge core_clk);
    fire <= 12'h000;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task final_report;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly 135 cycles that the sequence needs.
  initial
  begin
    #100000;
    failures++;
    final_report();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk({8'h00, rx_warmup_length, 4'h0, tx_cooldown_extension, tx_warmup_length}, 32'h00D203D2);
    for (int r = 0; r < 8; r++)
    begin
      rd(rows[r].a, d);
      chk(d, rows[r].rst);
      wr_rd(rows[r].a, rows[r].wd, d);
      chk(d, rows[r].rb);
    end
    chk({zone_upper_bound, zone_lower_bound}, 32'hFFFFA5A5);
    chk({26'h0, dc_comp_path_enable, radio_select_field}, 32'h00000003);
    chk({1'b0, round_trip_delay, rx_warmup_length, 4'h0, tx_cooldown_extension, tx_warmup_length},
      32'h7FFF0FFF);
    // A disabled diagnostic port must stay at zero even with a live profile word.
    chk(diag_out, 32'h0);
    @(posedge core_clk);
    diag_port_enable <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(diag_out, 32'hDEADBEEF);
    // Each fault in turn; checked faults first see a harmless case that must not set them.
    exp_f = 32'h0;
    for (int i = 0; i < 12; i++)
    begin
      if (`FAULT_MASK & (12'h001 << i))
      begin
        if (i == 10 || i == 7 || i == 2)
        begin
          shoot(i, 1'b1);
          chk({20'h0, link_fault_status}, exp_f);
        end
        shoot(i, 1'b0);
        exp_f = exp_f | (32'h1 << i);
        chk({20'h0, link_fault_status}, exp_f);
      end
    end
    wr(`FAULT_STATUS_OFS, 32'h0);
    rd(`FAULT_STATUS_OFS, d);
    chk(d, 32'h00000DFF);
    // A second reset in mid-run is the only way the flags clear.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk({20'h0, link_fault_status}, 32'h0);
    rd(`POWER_PHASE_OFS, d);
    chk(d, 32'h00D203D2);
    final_report();
  end
endmodule
